/* include/tec_map.svh */
// Purpose: register offsets, field positions and reset values of the timer channel
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define TEC_MODE_OFS     8'h00
`define TEC_CTRL_OFS     8'h04
`define TEC_COUNT_OFS    8'h08
`define TEC_STATUS_OFS   8'h0c

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define TEC_MODE_SEL_LSB 0
`define TEC_PULSE_BIT    2
`define TEC_POL_BIT      3
`define TEC_UDSRC_BIT    4
`define TEC_TWOPH_BIT    6
`define TEC_START_BIT    0
`define TEC_UDFLAG_BIT   1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TEC_MODE_RST     8'h00
`define TEC_COUNT_RST    16'h0000
`define TEC_ALL_ONES     16'hffff

`endif

/* include/tec_pkg.sv */
// Purpose: types shared by the timer channel files
// Assumes: nothing
// Notes:   constants live in tec_map.svh
package tec_pkg;

  typedef enum logic [1:0] {
    timer_mode = 2'b00,
    event_mode = 2'b01
  } op_mode_t;

endpackage

/* verilog/pin_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: inputs are levels, not pulses
// Notes:   only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pin_sync

`default_nettype wire

/* verilog/edge_decode.sv */
// Purpose: turns synchronised pin levels into count steps and a two-phase direction
// Assumes: inputs already synchronised to ref_clk
// Notes:   two-phase counts on both edges of phase a, direction from phase b
`timescale 1ns/1ps
`default_nettype none

module edge_decode (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic phase_a_pin,
  input  wire logic phase_b_pin,
  input  wire logic rising_sel,
  input  wire logic two_phase,
  output logic      step,
  output logic      step_up
);

  logic prev_a;
  logic next_prev_a;
  logic rise_a;
  logic fall_a;

  always_comb begin
    next_prev_a = phase_a_pin;
    rise_a      = phase_a_pin && !prev_a;
    fall_a      = !phase_a_pin && prev_a;
    if (two_phase) begin
      step    = rise_a || fall_a;
      // a leads b: up; b leads a: down
      step_up = rise_a ? !phase_b_pin : phase_b_pin;
    end else begin
      step    = rising_sel ? rise_a : fall_a;
      step_up = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_a <= 1'b0;
    end else begin
      prev_a <= next_prev_a;
    end
  end

endmodule // edge_decode

`default_nettype wire

/* verilog/timer_event_counter_channel.sv */
// Purpose: one 16-bit timer / event counter channel with APB registers
// Assumes: APB master keeps psel/penable protocol; pins are asynchronous
// Notes:   zero-wait APB; read data captured in the setup cycle
//
// Behaviour
// - pulse select set forces the out pin to pulse output, ignoring port direction, except in two-phase processing.
// - in timer mode with pulse output, out level toggles every underflow.
// - with start flag zero the pulse output stays low.
// - counter reads give live count, except all ones in a reload cycle.
// - counter written while stopped reads back the written value.
// - mode bits 1:0 equal to 01 select event counter mode.
// - event mode counts falling or rising edges of the input pin.
// - single-phase direction comes from software flag or steering pin.
// - on under/overflow the reload value is loaded and counting continues.
// - division ratio n+1 counting down, ffff-n+1 counting up.
// - start flag one runs the counter, zero halts it.
// - event mode raises interrupt request at each under/overflow.
// - out pin is general I/O, pulse output or steering input by configuration.
// - counter write while stopped updates reload and counter.
// - counter write while running updates only reload; counter takes it at reload.
// - two-phase channels count a pulse pair from both pins, direction from signals.
// - two-phase processing makes both pins inputs.
// - polarity bit zero counts falling edges, one rising edges.
// - up-down factor bit zero uses software flag, one uses out pin level.
// - software flag zero counts down, one counts up.
// - steering pin low counts down, high up; change applies at next valid edge.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.svh"

module timer_event_counter_channel #(
  parameter bit TWO_PHASE_OK = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_in_pin,
  input  wire logic        timer_out_pin_i,
  output logic             timer_out_pin_o,
  output logic             timer_out_pin_oe_b,
  input  wire logic        port_dir,
  input  wire logic        port_data,
  output logic             irq_req
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == `TEC_MODE_OFS) || (addr == `TEC_CTRL_OFS) ||
              (addr == `TEC_COUNT_OFS) || (addr == `TEC_STATUS_OFS);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic        start;
  logic        ud_flag;
  logic [15:0] cnt;
  logic [15:0] reload;
  logic        pulse_lvl;
  logic        last_up;
  logic [31:0] next_prdata;
  logic [7:0]  next_mode_reg;
  logic        next_start;
  logic        next_ud_flag;
  logic [15:0] next_cnt;
  logic [15:0] next_reload;
  logic        next_pulse_lvl;
  logic        next_last_up;
  logic        next_irq_req;

  logic [1:0]  pins_sync;
  logic        in_sync;
  logic        out_sync;
  logic        ev_step;
  logic        ev_up;

  tec_pkg::op_mode_t op_mode;
  logic        pulse_sel;
  logic        rising_sel;
  logic        ud_from_pin;
  logic        two_phase;
  logic        step;
  logic        up;
  logic        wrap;
  logic        wr;
  logic        rd_setup;

  assign op_mode     = tec_pkg::op_mode_t'(mode_reg[`TEC_MODE_SEL_LSB +: 2]);
  assign pulse_sel   = mode_reg[`TEC_PULSE_BIT];
  assign rising_sel  = mode_reg[`TEC_POL_BIT];
  assign ud_from_pin = mode_reg[`TEC_UDSRC_BIT];
  assign two_phase   = TWO_PHASE_OK && (op_mode == tec_pkg::event_mode) && mode_reg[`TEC_TWOPH_BIT];
  assign in_sync     = pins_sync[0];
  assign out_sync    = pins_sync[1];

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .async_in({timer_out_pin_i, timer_in_pin}),
    .sync_out(pins_sync)
  );

  edge_decode u_edge (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .phase_a_pin(in_sync),
    .phase_b_pin(out_sync),
    .rising_sel (rising_sel),
    .two_phase  (two_phase),
    .step       (ev_step),
    .step_up    (ev_up)
  );

  // ----------------------------------------------------------------
  // count engine
  // ----------------------------------------------------------------
  always_comb begin
    unique case (op_mode)
      tec_pkg::timer_mode: begin
        // count source prescaling is outside this channel
        step = 1'b1;
        up   = 1'b0;
      end
      tec_pkg::event_mode: begin
        step = ev_step;
        if (two_phase) begin
          up = ev_up;
        end else begin
          up = ud_from_pin ? out_sync : ud_flag;
        end
      end
      default: begin
        // remaining modes are not implemented: hold
        step = 1'b0;
        up   = 1'b0;
      end
    endcase
  end

  // wrap at 0 going down or ffff going up gives ratios n+1 and ffff-n+1
  assign wrap = start && step && (up ? (cnt == `TEC_ALL_ONES) : (cnt == `TEC_COUNT_RST));
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    next_mode_reg  = mode_reg;
    next_start     = start;
    next_ud_flag   = ud_flag;
    next_cnt       = cnt;
    next_reload    = reload;
    next_last_up   = last_up;
    next_prdata    = prdata;
    next_irq_req   = wrap;
    if (wr && paddr == `TEC_MODE_OFS) begin
      next_mode_reg = pwdata[7:0];
    end
    if (wr && paddr == `TEC_CTRL_OFS) begin
      next_start   = pwdata[`TEC_START_BIT];
      next_ud_flag = pwdata[`TEC_UDFLAG_BIT];
    end
    if (start && step) begin
      next_last_up = up;
      if (wrap) begin
        next_cnt = reload;
      end else if (up) begin
        next_cnt = cnt + 16'h0001;
      end else begin
        next_cnt = cnt - 16'h0001;
      end
    end
    if (wr && paddr == `TEC_COUNT_OFS) begin
      next_reload = pwdata[15:0];
      if (!start) begin
        next_cnt = pwdata[15:0];
      end
    end
    // level toggles on each wrap, forced low while halted
    if (!next_start) begin
      next_pulse_lvl = 1'b0;
    end else begin
      next_pulse_lvl = pulse_lvl ^ wrap;
    end
    if (rd_setup) begin
      unique case (paddr)
        `TEC_MODE_OFS:   next_prdata = {24'h000000, mode_reg};
        `TEC_CTRL_OFS:   next_prdata = {30'h0, ud_flag, start};
        // the count is being replaced in a reload cycle
        `TEC_COUNT_OFS:  next_prdata = {16'h0000, wrap ? `TEC_ALL_ONES : cnt};
        `TEC_STATUS_OFS: next_prdata = {29'h0, last_up, start, pulse_lvl};
        default:         next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg  <= `TEC_MODE_RST;
      start     <= 1'b0;
      ud_flag   <= 1'b0;
      cnt       <= `TEC_COUNT_RST;
      reload    <= `TEC_COUNT_RST;
      pulse_lvl <= 1'b0;
      last_up   <= 1'b0;
      prdata    <= 32'h00000000;
      irq_req   <= 1'b0;
    end else begin
      mode_reg  <= next_mode_reg;
      start     <= next_start;
      ud_flag   <= next_ud_flag;
      cnt       <= next_cnt;
      reload    <= next_reload;
      pulse_lvl <= next_pulse_lvl;
      last_up   <= next_last_up;
      prdata    <= next_prdata;
      irq_req   <= next_irq_req;
    end
  end

  // ----------------------------------------------------------------
  // bus answer and pin drive
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  always_comb begin
    if (two_phase) begin
      timer_out_pin_oe_b = 1'b1;
      timer_out_pin_o    = 1'b0;
    end else if (pulse_sel) begin
      timer_out_pin_oe_b = 1'b0;
      timer_out_pin_o    = pulse_lvl;
    end else if (op_mode == tec_pkg::event_mode && ud_from_pin) begin
      timer_out_pin_oe_b = 1'b1;
      timer_out_pin_o    = 1'b0;
    end else begin
      timer_out_pin_oe_b = !port_dir;
      timer_out_pin_o    = port_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pulse_override_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (pulse_sel && !two_phase) |-> (!timer_out_pin_oe_b && timer_out_pin_o == pulse_lvl))
    else $error("pulse select did not take the pin");

  pulse_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrap && next_start) |=> (pulse_lvl != $past(pulse_lvl)))
    else $error("pulse level did not toggle on wrap");

  stop_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!start) |-> (!pulse_lvl))
    else $error("pulse high while halted");

  reload_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rd_setup && paddr == `TEC_COUNT_OFS && wrap) |=> (prdata == 32'h0000ffff))
    else $error("reload cycle read not all ones");

  live_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rd_setup && paddr == `TEC_COUNT_OFS && !wrap) |=> (prdata[15:0] == $past(cnt)))
    else $error("count read not live");

  stopped_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr && paddr == `TEC_COUNT_OFS && !start) |=> (cnt == $past(pwdata[15:0]) && reload == cnt))
    else $error("stopped write missed counter");

  running_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr && paddr == `TEC_COUNT_OFS && start && !step) |=> (cnt == $past(cnt)))
    else $error("running write touched counter");

  down_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (start && step && !up && cnt != 16'h0000) |=> (cnt == $past(cnt) - 16'h0001))
    else $error("down count wrong");

  wrap_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrap) |=> (cnt == $past(reload) && irq_req))
    else $error("wrap did not reload");

  halt_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!start && !wr) |=> (cnt == $past(cnt)))
    else $error("counter moved while halted");

  two_phase_in_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (two_phase) |-> (timer_out_pin_oe_b))
    else $error("pin driven in two-phase");

endmodule // timer_event_counter_channel

`default_nettype wire

/* dv/pulse_source.sv */
// Purpose: far-side pin source: event pulses, steering level, two-phase pairs
// Assumes: pins are asynchronous levels; counting needs 3 edges to be seen
// Notes:   driven only through its tasks
`timescale 1ns/1ps
`default_nettype none

module pulse_source (
  input  wire logic ref_clk,
  output logic      a_pin,
  output logic      b_pin
);
  initial begin
    a_pin = 1'b1;
    b_pin = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one low pulse; 5 cycles each level so the synchroniser sees both edges
  task automatic pulse();
    @(posedge ref_clk);
    a_pin <= 1'b0;
    hold(5);
    a_pin <= 1'b1;
    hold(5);
  endtask

  task automatic steer(input logic lvl);
    @(posedge ref_clk);
    b_pin <= lvl;
    hold(5);
  endtask

  // b settles before a moves, as a real encoder pair would
  task automatic quad(input logic up);
    @(posedge ref_clk);
    b_pin <= a_pin ? up : ~up;
    hold(4);
    a_pin <= ~a_pin;
    hold(5);
  endtask
endmodule // pulse_source

`default_nettype wire

/* dv/tb_timer_event_counter_channel.sv */
// Purpose: self-checking bench for the timer / event counter channel
// Assumes: zero-wait APB, pins seen 3 edges after change
// Notes:   every scenario is one task
`timescale 1ns/1ps
`default_nettype none
`include "tec_map.svh"

module tb_timer_event_counter_channel;
  logic        ref_clk, rst_b, psel, penable, pwrite, port_dir, port_data;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, pin_o, pin_oe_b, irq_req, a_pin, b_pin, e;
  wire logic   pin_lvl;
  int          failures, compares, irqs, irq_base;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  assign pin_lvl = pin_oe_b ? b_pin : pin_o;

  timer_event_counter_channel timer_event_counter_channel_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_in_pin(a_pin), .timer_out_pin_i(pin_lvl), .timer_out_pin_o(pin_o),
    .timer_out_pin_oe_b(pin_oe_b), .port_dir(port_dir), .port_data(port_data), .irq_req(irq_req));

  pulse_source pulse_source_i (.ref_clk(ref_clk), .a_pin(a_pin), .b_pin(b_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (irq_req === 1'b1) irqs++;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic setup(input logic [7:0] mode, input logic [31:0] ctrl, input logic [31:0] n);
    wr(`TEC_CTRL_OFS, 32'h0);
    wr(`TEC_MODE_OFS, {24'h0, mode});
    wr(`TEC_COUNT_OFS, n);
    wr(`TEC_CTRL_OFS, ctrl);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(`TEC_MODE_OFS, 32'h0);
    rd(`TEC_COUNT_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(`TEC_COUNT_OFS, 32'h1234);
    rd(`TEC_COUNT_OFS, 32'h1234);
  endtask

  task automatic t_event_down();
    setup(8'h01, 32'h1, 32'h2);
    irq_base = irqs;
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'h1);
    wr(`TEC_COUNT_OFS, 32'h5);
    rd(`TEC_COUNT_OFS, 32'h1);
    pulse_source_i.pulse();
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'h5);
    chk(irqs - irq_base, 32'h1);
    wr(`TEC_CTRL_OFS, 32'h0);
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'h5);
  endtask

  task automatic t_event_up();
    setup(8'h09, 32'h3, 32'hfffd);
    irq_base = irqs;
    pulse_source_i.pulse();
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'hffff);
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'hfffd);
    chk(irqs - irq_base, 32'h1);
  endtask

  task automatic t_steer();
    port_dir <= 1'b1;
    port_data <= 1'b1;
    setup(8'h01, 32'h0, 32'ha);
    chk({30'h0, pin_oe_b, pin_o}, 32'h1);
    setup(8'h11, 32'h1, 32'ha);
    chk({31'h0, pin_oe_b}, 32'h1);
    pulse_source_i.steer(1'b1);
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'hb);
    rd(`TEC_STATUS_OFS, 32'h6);
    pulse_source_i.steer(1'b0);
    pulse_source_i.pulse();
    rd(`TEC_COUNT_OFS, 32'ha);
  endtask

  task automatic t_pulse_out();
    int   tog;
    logic last;
    port_dir <= 1'b0;
    setup(8'h04, 32'h0, 32'h3);
    chk({30'h0, pin_oe_b, pin_o}, 32'h0);
    wr(`TEC_CTRL_OFS, 32'h1);
    repeat (4) @(posedge ref_clk);
    tog = 0;
    last = pin_o;
    repeat (40) begin
      @(posedge ref_clk);
      if (pin_o !== last) tog++;
      last = pin_o;
    end
    chk(tog, 32'ha);
    wr(`TEC_CTRL_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, pin_o}, 32'h0);
    // reload value zero: every timer step is a reload cycle
    wr(`TEC_COUNT_OFS, 32'h0);
    wr(`TEC_CTRL_OFS, 32'h1);
    rd(`TEC_COUNT_OFS, 32'hffff);
    wr(`TEC_CTRL_OFS, 32'h0);
  endtask

  task automatic t_two_phase();
    setup(8'h41, 32'h1, 32'h5);
    chk({31'h0, pin_oe_b}, 32'h1);
    repeat (2) pulse_source_i.quad(1'b1);
    rd(`TEC_COUNT_OFS, 32'h7);
    repeat (3) pulse_source_i.quad(1'b0);
    rd(`TEC_COUNT_OFS, 32'h4);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; port_dir = 1'b0; port_data = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_event_down();
    t_event_up();
    t_steer();
    t_pulse_out();
    t_two_phase();
    test_done();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    test_done();
  end
endmodule // tb_timer_event_counter_channel

`default_nettype wire
